// ---- pkg/iocsw_pkg.sv ----
// Shared constants and carriers for the I/O connection status word bank.
// Assumes one clock domain and a connection engine that reports per-connection link state.
package iocsw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_CONN = 4;
  localparam int CONN_W = 2;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int LEN_W = 8;
  localparam int FILE_WORDS = 16;
  localparam logic [ADDR_W-1:0] WORDS_PER_CONN = 5'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: status file words, then one map entry per connection
  localparam logic [ADDR_W-1:0] ADDR_MAP_BASE = 5'h10;
  localparam logic [ADDR_W-1:0] MAP_RESET_STRIDE = 5'h03;
  localparam logic [1:0] WORD_CTRL = 2'h0;
  localparam logic [1:0] WORD_CODE_A = 2'h1;
  localparam logic [1:0] WORD_CODE_B = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions of the control and status word
  localparam int BIT_HOLD_PROGRAM = 0;
  localparam int BIT_INHIBIT = 1;
  localparam int BIT_NOTIFY_EN = 2;
  localparam int BIT_NEW_SAMPLE = 3;
  localparam int BIT_OVERFLOW = 4;
  localparam int BIT_IMM_INHIBIT = 5;
  localparam int BIT_DATA_INVALID = 8;
  localparam int BIT_CONN_ERROR = 9;
  localparam int BIT_UNDERRUN = 10;
  localparam int BIT_OVERRUN = 11;
  localparam int BIT_RUN_MODE = 15;

  // Writable control bits, and bits that software may only clear
  localparam logic [DATA_W-1:0] CTRL_MASK = 16'h0027;
  localparam logic [DATA_W-1:0] SW_CLEAR_MASK = 16'h0018;
  localparam logic [DATA_W-1:0] DEFINED_MASK = 16'h8F3F;
  // No connection yet: data invalid and connection error
  localparam logic [DATA_W-1:0] CTRL_WORD_RESET = 16'h0300;
  localparam logic [DATA_W-1:0] CODE_WORD_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    IOCSW_PEER_RECV,
    IOCSW_PEER_SEND,
    IOCSW_ADAPTER,
    IOCSW_BLOCK_XFER,
    IOCSW_OTHER
  } iocsw_conn_type_e;

  typedef struct packed {
    iocsw_conn_type_e conn_type;
    logic run_idle_support;
    logic lockout_config;
    logic [LEN_W-1:0] expected_len;
    logic [LEN_W-1:0] input_size;
  } iocsw_cfg_s;

  typedef struct packed {
    logic conn_up;
    logic data_lost;
    logic data_strobe;
    logic [LEN_W-1:0] data_len;
    logic target_run;
    logic peer_run;
    logic [DATA_W-1:0] listeners;
    logic [DATA_W-1:0] code_a;
    logic [DATA_W-1:0] code_b;
  } iocsw_link_in_s;

  typedef struct packed {
    logic open_allow;
    logic orderly_close;
    logic drop_now;
    logic force_program;
    logic restart_lockout;
    logic sample_ready;
  } iocsw_link_out_s;

  typedef struct packed {
    logic hit;
    logic [CONN_W-1:0] conn;
    logic [1:0] word;
  } iocsw_hit_s;

  function automatic logic [ADDR_W-1:0] map_reset(input int c);
    map_reset = ADDR_W'(c * int'(MAP_RESET_STRIDE));
  endfunction : map_reset

endpackage : iocsw_pkg

// ---- rtl/iocsw_code_words.sv ----
// Forms the second and third status words of one connection.
// Assumes the connection engine supplies cause codes and per-type status.
module iocsw_code_words (
  // Connection state
  input wire iocsw_pkg::iocsw_cfg_s cfg,
  input wire iocsw_pkg::iocsw_link_in_s link,
  input wire logic faulted,
  // Words
  output logic [iocsw_pkg::DATA_W-1:0] code_a,
  output logic [iocsw_pkg::DATA_W-1:0] code_b
);

  always_comb
  begin
    code_a = link.code_a;
    code_b = link.code_b;
    if (faulted)
    begin
      code_a = link.code_a; // R14
      code_b = link.code_b; // R14
    end
    else
    begin
      case (cfg.conn_type)
        iocsw_pkg::IOCSW_PEER_RECV:
        begin
          code_a = iocsw_pkg::CODE_WORD_RESET; // R19
          code_b = {{(iocsw_pkg::DATA_W-1){1'b0}}, link.peer_run}; // R19
        end
        iocsw_pkg::IOCSW_PEER_SEND:
        begin
          code_a = iocsw_pkg::CODE_WORD_RESET; // R20
          code_b = link.listeners; // R20
        end
        default:
        begin
          code_a = link.code_a;
          code_b = link.code_b;
        end
      endcase
    end
  end

endmodule : iocsw_code_words

// ---- rtl/iocsw_status_bank.sv ----
// Status file and map entries for the scheduled I/O connections.
// Assumes a synchronous register port and a connection engine on the same clock.
//
// Notes on behaviour
// R01: Each map entry holds an offset to three consecutive status words of its connection.
// R02: Bit 00 holds the connection in program mode; block transfers ignore it.
// R03: Bit 01 closes the connection orderly, keeps it closed, flags invalid and error.
// R04: With both inhibit bits clear the connection may be opened again.
// R05: Bit 02 enables sample-complete notification.
// R06: New-sample bit 03 sets on fresh data when enabled; software clears it.
// R07: Overflow bit 04 sets on fresh data while bit 03 is set; software clears.
// R08: Bit 05 drops all traffic at once, keeps it closed, flags invalid and error.
// R09: Immediate inhibit puts a lockout-configured adapter into restart lockout.
// R10: Data-invalid bit 08 sets when no data arrives or either inhibit is set.
// R11: Data-invalid clears when valid data arrives.
// R12: Connection-error bit 09 sets while unconnected or while either inhibit is set.
// R13: Connection-error clears once the connection is established.
// R14: On invalid data or failure the second and third words carry the cause code.
// R15: Underrun bit 10 on short data; invalid too when below input size.
// R16: Overrun bit 11 on long data; data-invalid unaffected.
// R17: Bit 15 shows target run or idle where run/idle notification is supported.
// R18: Software should gate critical logic on bits 08 and 09 before using data.
// R19: Peer receive without error: second word zero, third word peer run state.
// R20: Peer send without error: second word zero, third word listener count.
// R21: Undefined bits of the first word read zero and ignore writes.
module iocsw_status_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [iocsw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [iocsw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [iocsw_pkg::DATA_W-1:0] reg_rdata,
  // Controller mode
  input wire logic controller_run,
  // Connection configuration
  input wire iocsw_pkg::iocsw_cfg_s conn_cfg [iocsw_pkg::NUM_CONN],
  // Connection engine
  input wire iocsw_pkg::iocsw_link_in_s link_in [iocsw_pkg::NUM_CONN],
  output iocsw_pkg::iocsw_link_out_s link_out [iocsw_pkg::NUM_CONN]
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [iocsw_pkg::NUM_CONN-1:0][iocsw_pkg::ADDR_W-1:0] map_reg;
  logic [iocsw_pkg::NUM_CONN-1:0][iocsw_pkg::ADDR_W-1:0] map_next;
  logic [iocsw_pkg::DATA_W-1:0] ctrl_reg [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] ctrl_next [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] code_a_reg [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] code_a_next [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] code_b_reg [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] code_b_next [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] code_a_new [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] code_b_new [iocsw_pkg::NUM_CONN];
  logic faulted_next [iocsw_pkg::NUM_CONN];
  iocsw_pkg::iocsw_link_out_s link_out_reg [iocsw_pkg::NUM_CONN];
  iocsw_pkg::iocsw_link_out_s link_out_next [iocsw_pkg::NUM_CONN];
  logic [iocsw_pkg::DATA_W-1:0] rdata_reg;
  logic [iocsw_pkg::DATA_W-1:0] rdata_next;
  iocsw_pkg::iocsw_hit_s wr_hit;
  iocsw_pkg::iocsw_hit_s rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Lowest-numbered connection wins where map entries overlap
  function automatic iocsw_pkg::iocsw_hit_s file_decode(
    input logic [iocsw_pkg::ADDR_W-1:0] a,
    input logic [iocsw_pkg::NUM_CONN-1:0][iocsw_pkg::ADDR_W-1:0] offs
  );
    iocsw_pkg::iocsw_hit_s h;
    logic [iocsw_pkg::ADDR_W-1:0] d;
    h = '0;
    d = '0;
    if (a < iocsw_pkg::ADDR_MAP_BASE)
    begin
      for (int c = iocsw_pkg::NUM_CONN - 1; c >= 0; c--)
      begin
        d = a - offs[c];
        if (a >= offs[c] && d < iocsw_pkg::WORDS_PER_CONN) // R01
        begin
          h.hit = 1'b1;
          h.conn = iocsw_pkg::CONN_W'(c);
          h.word = d[1:0];
        end
      end
    end
    return h;
  endfunction : file_decode

  function automatic logic is_map_addr(input logic [iocsw_pkg::ADDR_W-1:0] a);
    return (a >= iocsw_pkg::ADDR_MAP_BASE) &&
           (a < iocsw_pkg::ADDR_MAP_BASE + iocsw_pkg::ADDR_W'(iocsw_pkg::NUM_CONN));
  endfunction : is_map_addr

  assign wr_hit = file_decode(reg_addr, map_reg);
  assign rd_hit = file_decode(reg_addr, map_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Cause code words
  for (genvar g = 0; g < iocsw_pkg::NUM_CONN; g++)
  begin : g_code
    iocsw_code_words u_code (
      .cfg(conn_cfg[g]),
      .link(link_in[g]),
      .faulted(faulted_next[g]),
      .code_a(code_a_new[g]),
      .code_b(code_b_new[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Map entries
  always_comb
  begin
    map_next = map_reg;
    if (reg_write && is_map_addr(reg_addr))
    begin
      map_next[reg_addr[iocsw_pkg::CONN_W-1:0]] = reg_wdata[iocsw_pkg::ADDR_W-1:0]; // R01
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < iocsw_pkg::NUM_CONN; c++)
      begin
        map_reg[c] <= iocsw_pkg::map_reset(c);
      end
    end
    else
    begin
      map_reg <= map_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-connection status and control
  always_comb
  begin
    logic [iocsw_pkg::DATA_W-1:0] w;
    logic inhibit;
    logic fresh;
    logic short_len;
    logic below_size;
    logic sw_hit;
    w = '0;
    inhibit = 1'b0;
    fresh = 1'b0;
    short_len = 1'b0;
    below_size = 1'b0;
    sw_hit = 1'b0;
    for (int c = 0; c < iocsw_pkg::NUM_CONN; c++)
    begin
      w = ctrl_reg[c];
      sw_hit = reg_write && wr_hit.hit && wr_hit.conn == iocsw_pkg::CONN_W'(c) &&
               wr_hit.word == iocsw_pkg::WORD_CTRL;
      // Software write: control bits stored, sticky flags cleared by zeros
      if (sw_hit)
      begin
        w = (w & ~iocsw_pkg::CTRL_MASK) | (reg_wdata & iocsw_pkg::CTRL_MASK); // R05
        w = w & (~iocsw_pkg::SW_CLEAR_MASK | reg_wdata); // R06 R07
      end
      inhibit = w[iocsw_pkg::BIT_INHIBIT] | w[iocsw_pkg::BIT_IMM_INHIBIT];
      // No traffic is accepted on an inhibited connection
      fresh = link_in[c].data_strobe && link_in[c].conn_up && !inhibit; // R03 R08
      short_len = link_in[c].data_len < conn_cfg[c].expected_len;
      below_size = link_in[c].data_len < conn_cfg[c].input_size;
      // Hardware sets win over a clear in the same cycle
      if (fresh && ctrl_reg[c][iocsw_pkg::BIT_NOTIFY_EN])
      begin
        if (ctrl_reg[c][iocsw_pkg::BIT_NEW_SAMPLE])
        begin
          w[iocsw_pkg::BIT_OVERFLOW] = 1'b1; // R07
        end
        w[iocsw_pkg::BIT_NEW_SAMPLE] = 1'b1; // R06
      end
      if (fresh)
      begin
        w[iocsw_pkg::BIT_UNDERRUN] = short_len; // R15
        w[iocsw_pkg::BIT_OVERRUN] = link_in[c].data_len > conn_cfg[c].expected_len; // R16
      end
      if (inhibit || link_in[c].data_lost || !link_in[c].conn_up)
      begin
        w[iocsw_pkg::BIT_DATA_INVALID] = 1'b1; // R10 R03 R08
      end
      else if (fresh)
      begin
        w[iocsw_pkg::BIT_DATA_INVALID] = below_size; // R11 R15
      end
      w[iocsw_pkg::BIT_CONN_ERROR] = inhibit || !link_in[c].conn_up; // R12 R13
      w[iocsw_pkg::BIT_RUN_MODE] = conn_cfg[c].run_idle_support &&
                                   link_in[c].target_run && !inhibit; // R17
      w = w & iocsw_pkg::DEFINED_MASK; // R21
      ctrl_next[c] = w;
      faulted_next[c] = w[iocsw_pkg::BIT_DATA_INVALID] | w[iocsw_pkg::BIT_CONN_ERROR];
      // Commands to the connection engine
      link_out_next[c].open_allow = !inhibit; // R04
      link_out_next[c].orderly_close = w[iocsw_pkg::BIT_INHIBIT] && !w[iocsw_pkg::BIT_IMM_INHIBIT]; // R03
      link_out_next[c].drop_now = w[iocsw_pkg::BIT_IMM_INHIBIT]; // R08
      link_out_next[c].restart_lockout = w[iocsw_pkg::BIT_IMM_INHIBIT] &&
                                         conn_cfg[c].conn_type == iocsw_pkg::IOCSW_ADAPTER &&
                                         conn_cfg[c].lockout_config; // R09
      link_out_next[c].force_program = !controller_run ||
                                       (w[iocsw_pkg::BIT_HOLD_PROGRAM] &&
                                        conn_cfg[c].conn_type != iocsw_pkg::IOCSW_BLOCK_XFER); // R02
      link_out_next[c].sample_ready = w[iocsw_pkg::BIT_NEW_SAMPLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause code next values
  // Kept out of the status process, which drives the faulted inputs of these words
  always_comb
  begin
    for (int c = 0; c < iocsw_pkg::NUM_CONN; c++)
    begin
      code_a_next[c] = code_a_new[c]; // R14
      code_b_next[c] = code_b_new[c]; // R14
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < iocsw_pkg::NUM_CONN; c++)
      begin
        ctrl_reg[c] <= iocsw_pkg::CTRL_WORD_RESET;
        code_a_reg[c] <= iocsw_pkg::CODE_WORD_RESET;
        code_b_reg[c] <= iocsw_pkg::CODE_WORD_RESET;
        link_out_reg[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < iocsw_pkg::NUM_CONN; c++)
      begin
        ctrl_reg[c] <= ctrl_next[c];
        code_a_reg[c] <= code_a_next[c];
        code_b_reg[c] <= code_b_next[c];
        link_out_reg[c] <= link_out_next[c];
      end
    end
  end

  assign link_out = link_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  // Data stands only in the cycle after the read strobe; unmapped reads give zero
  always_comb
  begin
    rdata_next = '0;
    if (reg_read)
    begin
      if (is_map_addr(reg_addr))
      begin
        rdata_next = {{(iocsw_pkg::DATA_W-iocsw_pkg::ADDR_W){1'b0}},
                      map_reg[reg_addr[iocsw_pkg::CONN_W-1:0]]};
      end
      else if (rd_hit.hit)
      begin
        case (rd_hit.word)
          iocsw_pkg::WORD_CTRL:
          begin
            rdata_next = ctrl_reg[rd_hit.conn] & iocsw_pkg::DEFINED_MASK; // R21
          end
          iocsw_pkg::WORD_CODE_A:
          begin
            rdata_next = code_a_reg[rd_hit.conn];
          end
          iocsw_pkg::WORD_CODE_B:
          begin
            rdata_next = code_b_reg[rd_hit.conn];
          end
          default:
          begin
            rdata_next = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : iocsw_status_bank

// ---- sim/iocsw_checker.sv ----
// Port checker for the status bank, bound onto every instance.
// Assumes map entry 0 keeps offset 0 while it watches.
module iocsw_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [iocsw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [iocsw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [iocsw_pkg::DATA_W-1:0] reg_rdata,
  // Mode and connections
  input wire logic controller_run,
  input wire iocsw_pkg::iocsw_cfg_s conn_cfg [iocsw_pkg::NUM_CONN],
  input wire iocsw_pkg::iocsw_link_in_s link_in [iocsw_pkg::NUM_CONN],
  input wire iocsw_pkg::iocsw_link_out_s link_out [iocsw_pkg::NUM_CONN]
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_ctrl0_wr;
    reg_write && reg_addr == 5'h00;
  endsequence
  sequence s_close_seen;
    link_out[0].orderly_close && !link_out[0].open_allow;
  endsequence
  inhibit_close_a: assert property (s_ctrl0_wr ##0 (reg_wdata[1] && !reg_wdata[5]) |-> ##[1:2] s_close_seen)
    else $error("orderly close missing after inhibit write");
  imm_drop_a: assert property (s_ctrl0_wr ##0 reg_wdata[5] |-> ##[1:2] link_out[0].drop_now)
    else $error("drop missing after immediate inhibit write");
  open_rule_a: assert property ($past(rstn) |->
    link_out[0].open_allow == !(link_out[0].orderly_close || link_out[0].drop_now))
    else $error("open allow disagrees with inhibit outputs");
  lockout_set_a: assert property (link_out[0].restart_lockout |-> link_out[0].drop_now &&
    conn_cfg[0].lockout_config && conn_cfg[0].conn_type == iocsw_pkg::IOCSW_ADAPTER)
    else $error("restart lockout without cause");
  prog_force_a: assert property (!controller_run |=> link_out[0].force_program)
    else $error("program mode not forced");
  block_ign_a: assert property (controller_run &&
    conn_cfg[1].conn_type == iocsw_pkg::IOCSW_BLOCK_XFER |=> !link_out[1].force_program)
    else $error("block transfer forced to program");
  sample_set_a: assert property ($rose(link_out[0].sample_ready) |->
    $past(link_in[0].data_strobe && link_in[0].conn_up))
    else $error("new sample set without fresh data");
  rsv_bits_a: assert property ($past(reg_read) && $past(reg_addr) == 5'h00 |->
    (reg_rdata & ~iocsw_pkg::DEFINED_MASK) == 16'h0000)
    else $error("undefined control bits read nonzero");
endmodule : iocsw_checker

bind iocsw_status_bank iocsw_checker u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .controller_run(controller_run), .conn_cfg(conn_cfg), .link_in(link_in), .link_out(link_out));

// ---- sim/iocsw_remote_model.sv ----
// Far-node model: connection engine and remote targets of every connection.
// Assumes the bank's link outputs are registered levels on the same clock.
module iocsw_remote_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bank side
  input wire iocsw_pkg::iocsw_link_out_s link_out [iocsw_pkg::NUM_CONN],
  output iocsw_pkg::iocsw_link_in_s link_in [iocsw_pkg::NUM_CONN],
  // Scenario control
  input wire logic send,
  input wire logic [7:0] len
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk or negedge rstn)
  begin
    for (int c = 0; c < iocsw_pkg::NUM_CONN; c++)
    begin
      if (!rstn)
      begin
        link_in[c] <= '0;
        link_in[c].data_lost <= 1'b1;
      end
      else
      begin
        // Opens one cycle after the bank allows it
        link_in[c].conn_up <= link_out[c].open_allow;
        link_in[c].data_lost <= !link_in[c].conn_up;
        link_in[c].data_strobe <= send && link_in[c].conn_up;
        // Length lines toggle while no frame is sent
        link_in[c].data_len <= send ? len : ~link_in[c].data_len;
        link_in[c].target_run <= !link_out[c].force_program;
        link_in[c].peer_run <= !link_out[c].force_program;
        link_in[c].listeners <= 16'h0002;
        link_in[c].code_a <= link_in[c].conn_up ? 16'h0000 : 16'h0011;
        link_in[c].code_b <= 16'h0204;
      end
    end
  end
endmodule : iocsw_remote_model

// ---- sim/testbench.sv ----
// Self-checking bench for the status bank and its far-node model.
// Assumes package, design, checker and model are compiled before it.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rstn;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic controller_run;
  logic send;
  logic [7:0] len;
  iocsw_pkg::iocsw_cfg_s cfg [iocsw_pkg::NUM_CONN];
  iocsw_pkg::iocsw_link_in_s link_in [iocsw_pkg::NUM_CONN];
  iocsw_pkg::iocsw_link_out_s link_out [iocsw_pkg::NUM_CONN];
  int n_mismatch;
  int check_count;
  iocsw_status_bank dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .controller_run(controller_run),
    .conn_cfg(cfg), .link_in(link_in), .link_out(link_out));
  iocsw_remote_model far (.clk(clk), .rstn(rstn), .link_out(link_out), .link_in(link_in),
    .send(send), .len(len));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic snd(input logic [7:0] l);
    @(posedge clk);
    send <= 1'b1;
    len <= l;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : snd
  task automatic stop_test();
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(5'h00, 16'h8100);
    rd(5'h11, 16'h0003);
    rd(5'h01, 16'h0000);
    rd(5'h02, 16'h0204);
  endtask : t_reset
  task automatic t_sample();
    wr(5'h00, 16'h0004);
    snd(8'h08);
    rd(5'h00, 16'h800C);
    chk(16'(link_out[0].sample_ready), 16'h0001);
    snd(8'h08);
    rd(5'h00, 16'h801C);
    wr(5'h00, 16'h0004);
    rd(5'h00, 16'h8004);
    chk(16'(link_out[0].sample_ready), 16'h0000);
    wr(5'h00, 16'h70C4);
    rd(5'h00, 16'h8004);
  endtask : t_sample
  task automatic t_len();
    wr(5'h00, 16'h0000);
    snd(8'h04);
    rd(5'h00, 16'h8500);
    snd(8'h07);
    rd(5'h00, 16'h8400);
    snd(8'h0C);
    rd(5'h00, 16'h8800);
  endtask : t_len
  task automatic t_inhibit();
    wr(5'h00, 16'h0002);
    repeat (4) @(posedge clk);
    chk(16'(link_out[0].orderly_close), 16'h0001);
    rd(5'h00, 16'h0B02);
    rd(5'h01, 16'h0011);
    wr(5'h00, 16'h0000);
    repeat (4) @(posedge clk);
    chk(16'(link_out[0].open_allow), 16'h0001);
    snd(8'h08);
    rd(5'h00, 16'h8000);
  endtask : t_inhibit
  task automatic t_imm();
    wr(5'h00, 16'h0020);
    repeat (4) @(posedge clk);
    chk(16'(link_out[0].drop_now), 16'h0001);
    chk(16'(link_out[0].restart_lockout), 16'h0001);
    rd(5'h00, 16'h0320);
    wr(5'h00, 16'h0000);
    repeat (4) @(posedge clk);
  endtask : t_imm
  task automatic t_mode();
    controller_run <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++)
      chk(16'(link_out[i].force_program), 16'h0001);
    rd(5'h00, 16'h0100);
    rd(5'h08, 16'h0000);
    controller_run <= 1'b1;
    wr(5'h03, 16'h0001);
    wr(5'h00, 16'h0001);
    repeat (3) @(posedge clk);
    chk(16'(link_out[1].force_program), 16'h0000);
    chk(16'(link_out[0].force_program), 16'h0001);
    wr(5'h03, 16'h0000);
    wr(5'h00, 16'h0000);
    repeat (4) @(posedge clk);
  endtask : t_mode
  task automatic t_peer();
    rd(5'h06, 16'h8000);
    rd(5'h07, 16'h0000);
    rd(5'h08, 16'h0001);
    rd(5'h0A, 16'h0000);
    rd(5'h0B, 16'h0002);
  endtask : t_peer
  task automatic t_map();
    wr(5'h11, 16'h000C);
    wr(5'h0C, 16'h0004);
    rd(5'h0C, 16'h0004);
    rd(5'h03, 16'h0000);
    rd(5'h11, 16'h000C);
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
  endtask : t_map
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The scenarios need about 150 cycles
  initial
  begin
    #50000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    rstn = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    controller_run = 1'b1;
    send = 1'b0;
    len = 8'h00;
    n_mismatch = 0;
    check_count = 0;
    cfg[0] = '{iocsw_pkg::IOCSW_ADAPTER, 1'b1, 1'b1, 8'h08, 8'h06};
    cfg[1] = '{iocsw_pkg::IOCSW_BLOCK_XFER, 1'b0, 1'b0, 8'h08, 8'h06};
    cfg[2] = '{iocsw_pkg::IOCSW_PEER_RECV, 1'b1, 1'b0, 8'h08, 8'h06};
    cfg[3] = '{iocsw_pkg::IOCSW_PEER_SEND, 1'b0, 1'b0, 8'h08, 8'h06};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_sample();
    t_len();
    t_inhibit();
    t_imm();
    t_mode();
    t_peer();
    t_map();
    stop_test();
  end
endmodule : testbench
